// ==== rtl/mmn_cfg.svh ====
// Purpose: Constants for the move, multiply and negate execution block.
// Assumes: Included by the package and every module file of the block.
// Notes: Byte offsets on the register bus, opcode patterns, field positions, reset values.
`ifndef MMN_CFG_SVH
`define MMN_CFG_SVH
`define MMN_OFF_INSTR   12'h000
`define MMN_OFF_ACC     12'h004
`define MMN_OFF_FLAGS   12'h008
`define MMN_OFF_PROD    12'h00c
`define MMN_OFF_STATUS  12'h010
`define MMN_OFF_RETIRE  12'h014
`define MMN_OPC_MOVE    8'h01
`define MMN_OPC_MULL    8'hbc
`define MMN_OPC_MULR    8'h34
`define MMN_OPC_NEG     7'h16
`define MMN_SEL_BIT     8
`define MMN_ST_BUSY     0
`define MMN_ST_UNSUP    1
`define MMN_ST_NOMUL    2
`define MMN_RST_INSTR   16'h0000
`define MMN_RST_ACC     8'h00
`define MMN_RST_FLAGS   4'h0
`define MMN_RST_PROD    16'h0000
`define MMN_RST_RETIRE  16'h0000
`endif

// ==== rtl/mmn_pkg.sv ====
// Purpose: Types and shared decoding for the execution block.
// Assumes: The constants header is available on the include path.
// Notes: Phases and operations are one-hot enumerations.
`include "mmn_cfg.svh"
`default_nettype none
package mmn_pkg;
   typedef enum logic [4:0] {
      MMN_PH_IDLE = 5'b00001,
      MMN_PH_Q1   = 5'b00010,
      MMN_PH_Q2   = 5'b00100,
      MMN_PH_Q3   = 5'b01000,
      MMN_PH_Q4   = 5'b10000
   } mmn_phase_t;
   typedef enum logic [4:0] {
      MMN_OP_NONE = 5'b00001,
      MMN_OP_MOVE = 5'b00010,
      MMN_OP_MULL = 5'b00100,
      MMN_OP_MULR = 5'b01000,
      MMN_OP_NEG  = 5'b10000
   } mmn_op_t;
   typedef struct packed {
      logic ov;
      logic z;
      logic dc;
      logic c;
   } mmn_flags_t;
   typedef struct packed {
      logic [15:0] prod;
      logic [7:0]  res;
      mmn_flags_t  flags;
      logic        wr_acc;
      logic        wr_reg;
      logic        wr_prod;
      logic        wr_flags;
   } mmn_alu_out_t;
   typedef struct packed {
      logic       re;
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mmn_rf_req_t;
   typedef struct packed {
      mmn_phase_t ph;
   } mmn_phg_state_t;
   typedef struct packed {
      logic [15:0] ir;
      mmn_op_t     op;
      logic [7:0]  acc;
      logic [7:0]  opnd;
      mmn_flags_t  flags;
      logic [15:0] prod;
      mmn_rf_req_t rf;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        unsup;
      logic [15:0] retire;
   } mmn_state_t;
   function automatic mmn_op_t mmn_decode(input logic [15:0] ir, input logic has_mul);
      mmn_op_t op;
      op = MMN_OP_NONE;
      if (ir[15:8] == `MMN_OPC_MOVE)
         op = MMN_OP_MOVE;
      else if (has_mul && ir[15:8] == `MMN_OPC_MULL)
         op = MMN_OP_MULL;
      else if (has_mul && ir[15:8] == `MMN_OPC_MULR)
         op = MMN_OP_MULR;
      else if (ir[15:9] == `MMN_OPC_NEG)
         op = MMN_OP_NEG;
      return op;
   endfunction
   function automatic logic [31:0] mmn_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            m[8*i +: 8] = wd[8*i +: 8];
      return m;
   endfunction
endpackage
`default_nettype wire

// ==== rtl/mmn_phase_gen.sv ====
// Purpose: Sequencer of the four phases of one instruction cycle.
// Assumes: A launch pulse only arrives while idle.
// Notes: Advances one phase per clock.
`include "mmn_cfg.svh"
`default_nettype none
module mmn_phase_gen
   import mmn_pkg::*;
(
   // Clock and reset.
   input  wire logic   clk_sys,
   input  wire logic   arst_n,
   // Control.
   input  wire logic   launch,
   output var mmn_phase_t phase
);
   mmn_phg_state_t st_r;
   mmn_phg_state_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      unique case (st_r.ph)
         MMN_PH_IDLE: if (launch) st_nxt.ph = MMN_PH_Q1;
         MMN_PH_Q1:   st_nxt.ph = MMN_PH_Q2;
         MMN_PH_Q2:   st_nxt.ph = MMN_PH_Q3;
         MMN_PH_Q3:   st_nxt.ph = MMN_PH_Q4;
         MMN_PH_Q4:   st_nxt.ph = MMN_PH_IDLE;
         default:     st_nxt.ph = MMN_PH_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         st_r <= '{ph: MMN_PH_IDLE};
      else
         st_r <= st_nxt;
   end

   assign phase = st_r.ph;
endmodule
`default_nettype wire

// ==== rtl/mmn_alu.sv ====
// Purpose: Combinational execute stage for move, multiply and negate.
// Assumes: Operation code arrives already decoded and stable during execute.
// Notes: Without the multiplier the product path is a constant.
`include "mmn_cfg.svh"
`default_nettype none
module mmn_alu
   import mmn_pkg::*;
#(
   parameter bit HAS_MUL = 1'b1
)
(
   // Operands.
   input  wire mmn_op_t    op,
   input  wire logic       sel,
   input  wire logic [7:0] acc,
   input  wire logic [7:0] opnd,
   input  wire mmn_flags_t flags_in,
   // Result.
   output mmn_alu_out_t    res
);
   logic [15:0] prod;
   logic [8:0]  neg_sum;
   logic [4:0]  neg_nib;

   generate
      if (HAS_MUL)
      begin : g_mul
         assign prod = {8'h00, acc} * {8'h00, opnd};
      end
      else
      begin : g_nomul
         assign prod = `MMN_RST_PROD;
      end
   endgenerate

   assign neg_sum = {1'b0, ~acc} + 9'h001;
   assign neg_nib = {1'b0, ~acc[3:0]} + 5'h01;

   always_comb
   begin
      res = '0;
      res.flags = flags_in;
      unique case (op)
         MMN_OP_MOVE:
         begin
            res.res = acc;
            res.wr_reg = 1'b1;
         end
         MMN_OP_MULL, MMN_OP_MULR:
         begin
            // Flags pass through untouched; no zero test is made on the product.
            res.prod = prod;
            res.wr_prod = 1'b1;
         end
         MMN_OP_NEG:
         begin
            res.res = neg_sum[7:0];
            res.flags.c = neg_sum[8];
            res.flags.dc = neg_nib[4];
            res.flags.z = (neg_sum[7:0] == 8'h00);
            res.flags.ov = acc[7] & neg_sum[7];
            res.wr_flags = 1'b1;
            res.wr_reg = 1'b1;
            res.wr_acc = ~sel;
         end
         MMN_OP_NONE:
         begin
            res.wr_reg = 1'b0;
         end
         default:
         begin
            res.wr_reg = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

// ==== rtl/mmn_exec.sv ====
// Purpose: Execution datapath for accumulator move, 8x8 multiply and accumulator negate.
// Assumes: APB master per protocol; register file read data valid while its read strobe is high.
// Notes: One instruction at a time, issued by writing the instruction register.
//        The bus answers with no wait state; busy is judged at the setup cycle.
//        Refused writes change nothing, so software must poll busy before issuing.
//
// Notes on behaviour
// - Move opcode 0x01ff copies accumulator to register f, accumulator and flags kept.
// - Literal multiply 0xbckk multiplies accumulator by the low opcode byte, unsigned.
// - Both multiplies write the full 16-bit product in the same instruction.
// - Upper product byte goes to the high register, lower to the low register.
// - Multiplies change no flag; no carry, overflow or zero is produced.
// - Register multiply 0x34ff multiplies accumulator by register file byte f.
// - Multiplies leave accumulator and source register unchanged.
// - A zero product is never detected or flagged.
// - Negate forms inverse plus one and updates overflow, carry, digit carry, zero.
// - Negate select bit 0 writes accumulator and register, 1 writes register only.
// - The reduced variant lacks both multiplies, the multiplier and product registers.
`include "mmn_cfg.svh"
`default_nettype none
module mmn_exec
   import mmn_pkg::*;
#(
   parameter bit HAS_MUL = 1'b1
)
(
   // Clock and reset.
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // APB slave.
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Register file port.
   input  wire logic [7:0]  rf_rdata,
   output logic [7:0]       rf_addr,
   output logic             rf_re,
   output logic             rf_we,
   output logic [7:0]       rf_wdata,
   // Core state.
   output logic [7:0]       working_accumulator,
   output logic [7:0]       product_high_byte,
   output logic [7:0]       product_low_byte,
   output logic             overflow_flag,
   output logic             zero_flag,
   output logic             digit_carry_flag,
   output logic             carry_flag,
   output mmn_phase_t       instr_phase
);
   mmn_state_t   st_r;
   mmn_state_t   st_nxt;
   mmn_phase_t   phase;
   mmn_alu_out_t alu;
   logic         launch;
   logic         busy;
   logic         setup;
   logic         wr_go;
   logic         rd_err;
   logic         wr_err;
   logic [31:0]  rd_mux;
   logic [31:0]  merged;
   mmn_op_t      dec_op;

   mmn_phase_gen u_phase (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .launch  (launch),
      .phase   (phase)
   );

   mmn_alu #(
      .HAS_MUL (HAS_MUL)
   ) u_alu (
      .op       (st_r.op),
      .sel      (st_r.ir[`MMN_SEL_BIT]),
      .acc      (st_r.acc),
      .opnd     (st_r.opnd),
      .flags_in (st_r.flags),
      .res      (alu)
   );

   // Busy spans the four phases; bus writes to instruction, accumulator and flags are refused meanwhile.
   assign busy = (phase != MMN_PH_IDLE);
   assign setup = psel & ~penable;
   assign merged = mmn_merge(rd_mux, pwdata, pstrb);
   // One decoder feeds the operation, the unsupported flag and the read strobe.
   assign dec_op = mmn_decode(st_r.ir, HAS_MUL);

   // Read data and error for the address held during the setup cycle.
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      wr_err = 1'b0;
      unique case (paddr)
         `MMN_OFF_INSTR:
         begin
            rd_mux = {16'h0000, st_r.ir};
            wr_err = busy;
         end
         `MMN_OFF_ACC:
         begin
            rd_mux = {24'h00_0000, st_r.acc};
            wr_err = busy;
         end
         `MMN_OFF_FLAGS:
         begin
            rd_mux = {28'h000_0000, st_r.flags};
            wr_err = busy;
         end
         `MMN_OFF_PROD:
         begin
            // The reduced variant has no product registers, so the word is unmapped.
            rd_mux = {16'h0000, st_r.prod};
            rd_err = ~HAS_MUL;
            wr_err = 1'b1;
         end
         `MMN_OFF_STATUS:
         begin
            rd_mux[`MMN_ST_BUSY] = busy;
            rd_mux[`MMN_ST_UNSUP] = st_r.unsup;
            rd_mux[`MMN_ST_NOMUL] = ~HAS_MUL;
            wr_err = 1'b1;
         end
         `MMN_OFF_RETIRE:
         begin
            rd_mux = {16'h0000, st_r.retire};
         end
         default:
         begin
            rd_err = 1'b1;
            wr_err = 1'b1;
         end
      endcase
      if (rd_err)
      begin
         rd_mux = 32'h0000_0000;
         wr_err = 1'b1;
      end
   end

   // A write lands only at the access edge, and only if its setup cycle accepted it.
   assign wr_go = psel & penable & st_r.pready & pwrite & ~st_r.pslverr;
   assign launch = wr_go && (paddr == `MMN_OFF_INSTR);

   always_comb
   begin
      st_nxt = st_r;
      // Zero wait states: the answer is prepared in setup and shown in the access cycle.
      st_nxt.pready = setup;
      if (setup)
      begin
         // Writes return zero so the data lines never show a stale read.
         st_nxt.prdata = pwrite ? 32'h0000_0000 : rd_mux;
         st_nxt.pslverr = pwrite ? wr_err : rd_err;
      end
      else
      begin
         st_nxt.pslverr = 1'b0;
      end

      // Software writes; instruction, accumulator and flags writes are refused while an instruction runs, so they never have two writers.
      if (wr_go)
      begin
         unique case (paddr)
            `MMN_OFF_INSTR:
            begin
               st_nxt.ir = merged[15:0];
            end
            `MMN_OFF_ACC:
            begin
               st_nxt.acc = merged[7:0];
            end
            `MMN_OFF_FLAGS:
            begin
               st_nxt.flags = merged[3:0];
            end
            `MMN_OFF_RETIRE:
            begin
               st_nxt.retire = `MMN_RST_RETIRE;
            end
            default:
            begin
               st_nxt.retire = st_nxt.retire;
            end
         endcase
      end

      unique case (phase)
         MMN_PH_IDLE:
         begin
            st_nxt.rf.we = 1'b0;
         end
         MMN_PH_Q1:
         begin
            // Decode and present the file address for the operand read.
            st_nxt.op = dec_op;
            st_nxt.unsup = (dec_op == MMN_OP_NONE);
            st_nxt.rf.addr = st_r.ir[7:0];
            st_nxt.rf.re = (dec_op == MMN_OP_MULR);
         end
         MMN_PH_Q2:
         begin
            st_nxt.rf.re = 1'b0;
            // Operand read: the file byte for register multiply, else the literal.
            if (st_r.op == MMN_OP_MULR)
            begin
               st_nxt.opnd = rf_rdata;
            end
            else
            begin
               st_nxt.opnd = st_r.ir[7:0];
            end
         end
         MMN_PH_Q3:
         begin
            // Accumulator, product and flags land at the end of execute; the file write strobe is raised for Q4.
            if (alu.wr_acc)
            begin
               st_nxt.acc = alu.res;
            end
            if (alu.wr_prod)
            begin
               st_nxt.prod = alu.prod;
            end
            if (alu.wr_flags)
            begin
               st_nxt.flags = alu.flags;
            end
            st_nxt.rf.we = alu.wr_reg;
            if (alu.wr_reg)
            begin
               st_nxt.rf.wdata = alu.res;
            end
         end
         MMN_PH_Q4:
         begin
            // Retire count increments after a same-cycle clear, so no instruction is lost.
            st_nxt.rf.we = 1'b0;
            st_nxt.retire = st_nxt.retire + 16'h0001;
         end
         default:
         begin
            st_nxt.rf.we = 1'b0;
         end
      endcase

      // Without the multiplier the product register has no writer and folds away.
      if (!HAS_MUL)
      begin
         st_nxt.prod = `MMN_RST_PROD;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // Constants only here; the sequencer resets alongside to idle.
         st_r.ir <= `MMN_RST_INSTR;
         st_r.op <= MMN_OP_NONE;
         st_r.acc <= `MMN_RST_ACC;
         st_r.opnd <= 8'h00;
         st_r.flags <= `MMN_RST_FLAGS;
         st_r.prod <= `MMN_RST_PROD;
         st_r.rf <= '0;
         st_r.pready <= 1'b0;
         st_r.pslverr <= 1'b0;
         st_r.prdata <= 32'h0000_0000;
         st_r.unsup <= 1'b0;
         st_r.retire <= `MMN_RST_RETIRE;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Every output below is a flip-flop of the state record or of the sequencer.
   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign rf_addr = st_r.rf.addr;
   assign rf_re = st_r.rf.re;
   assign rf_we = st_r.rf.we;
   assign rf_wdata = st_r.rf.wdata;
   assign working_accumulator = st_r.acc;
   assign product_high_byte = st_r.prod[15:8];
   assign product_low_byte = st_r.prod[7:0];
   assign overflow_flag = st_r.flags.ov;
   assign zero_flag = st_r.flags.z;
   assign digit_carry_flag = st_r.flags.dc;
   assign carry_flag = st_r.flags.c;
   assign instr_phase = phase;
endmodule
`default_nettype wire

// ==== rtl/mmn_none.sv ====
`default_nettype none
`default_nettype wire

// ==== verif/mmn_exec_asserts.sv ====
// Purpose: Port-level checks of the execution block.
// Assumes: Instructions are written with all byte lanes enabled.
// Notes: The opcode is captured from the bus because decoding is internal.
`include "mmn_cfg.svh"
`default_nettype none
module mmn_exec_asserts
   import mmn_pkg::*;
#(
   parameter bit HAS_MUL = 1'b1
)
(
   // Clock and reset.
   input wire logic       clk_sys,
   input wire logic       arst_n,
   // Bus.
   input wire logic [11:0] paddr,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic [31:0] pwdata,
   input wire logic       pready,
   input wire logic       pslverr,
   // Register file and core state.
   input wire logic [7:0] rf_rdata,
   input wire logic [7:0] rf_addr,
   input wire logic       rf_re,
   input wire logic       rf_we,
   input wire logic [7:0] rf_wdata,
   input wire logic [7:0] working_accumulator,
   input wire logic [7:0] product_high_byte,
   input wire logic [7:0] product_low_byte,
   input wire logic       overflow_flag,
   input wire logic       zero_flag,
   input wire logic       digit_carry_flag,
   input wire logic       carry_flag,
   input wire mmn_phase_t instr_phase
);
   logic [15:0] ir_r;
   logic [7:0]  a_q;
   logic [7:0]  b_q;
   logic [3:0]  f_q;
   wire logic go = psel && penable && pready && pwrite && !pslverr && paddr == `MMN_OFF_INSTR;
   wire logic [3:0] flg = {overflow_flag, zero_flag, digit_carry_flag, carry_flag};
   wire logic [15:0] prod = {product_high_byte, product_low_byte};
   wire logic mull = HAS_MUL && ir_r[15:8] == `MMN_OPC_MULL;
   wire logic mulr = HAS_MUL && ir_r[15:8] == `MMN_OPC_MULR;
   wire logic mul = mull || mulr;
   wire logic move = ir_r[15:8] == `MMN_OPC_MOVE;
   wire logic neg = ir_r[15:9] == `MMN_OPC_NEG;
   wire logic q4 = instr_phase == MMN_PH_Q4;
   // Accumulator and flags are frozen at Q1, the register operand at Q2, so that Q4 results can be judged against them.
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         {ir_r, a_q, b_q, f_q} <= 36'h0;
      else
      begin
         if (go)
            ir_r <= pwdata[15:0];
         if (instr_phase == MMN_PH_Q1)
            {a_q, f_q} <= {working_accumulator, flg};
         if (instr_phase == MMN_PH_Q2 && rf_re)
            b_q <= rf_rdata;
      end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   a_launch_q1: assert property (go |=> instr_phase == MMN_PH_Q1)
      else $error("instruction did not start");
   a_phase_order: assert property (instr_phase == MMN_PH_Q1 |=>
      instr_phase == MMN_PH_Q2 ##1 instr_phase == MMN_PH_Q3 ##1 instr_phase == MMN_PH_Q4)
      else $error("phase order");
   a_mul_product: assert property (q4 && mul |->
      prod == 16'(a_q) * 16'(mull ? ir_r[7:0] : b_q)) else $error("wrong product");
   a_mul_keep: assert property (q4 && mul |->
      !rf_we && working_accumulator == a_q && flg == f_q) else $error("multiply side effect");
   a_mulr_read: assert property (instr_phase == MMN_PH_Q2 && mulr |-> rf_re
      && rf_addr == ir_r[7:0]) else $error("register operand not read");
   a_move_write: assert property (q4 && move |-> rf_we && rf_addr == ir_r[7:0]
      && rf_wdata == a_q && flg == f_q) else $error("move wrong");
   a_neg_value: assert property (q4 && neg |->
      rf_we && rf_wdata == 8'(~a_q + 8'h01)
      && working_accumulator == (ir_r[8] ? a_q : rf_wdata)) else $error("negate result");
   a_neg_flags: assert property (q4 && neg |-> zero_flag == (rf_wdata == 8'h00)
      && overflow_flag == (a_q == 8'h80) && carry_flag == (a_q == 8'h00)
      && digit_carry_flag == (a_q[3:0] == 4'h0))
      else $error("negate flags");
   a_no_mult: assert property (!HAS_MUL |-> prod == 16'h0000)
      else $error("product present without multiplier");
   cover property (q4 && mull);
   cover property (q4 && mulr);
   cover property (q4 && neg && ir_r[8]);
endmodule
bind mmn_exec mmn_exec_asserts #(.HAS_MUL(HAS_MUL)) mmn_exec_asserts_i (.clk_sys, .arst_n,
   .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr, .rf_rdata, .rf_addr, .rf_re,
   .rf_we, .rf_wdata, .working_accumulator, .product_high_byte, .product_low_byte,
   .overflow_flag, .zero_flag, .digit_carry_flag, .carry_flag, .instr_phase);
`default_nettype wire

// ==== verif/mmn_exec_bench.sv ====
// Purpose: Self-checking bench of the execution block.
// Assumes: The bench stands in for the register file; a reduced instance shares the bus.
// Notes: Each instruction is awaited by polling the busy bit.
`include "mmn_cfg.svh"
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module mmn_exec_bench
   import mmn_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] prdata0;
   logic pslverr0;
   logic [7:0] ph0;
   logic [7:0] pl0;
   logic [7:0] rf_rdata;
   logic [7:0] rf_val = 8'h00;
   logic [7:0] rf_addr;
   logic rf_re;
   logic rf_we;
   logic [7:0] rf_wdata;
   logic [7:0] acc;
   logic [7:0] ph;
   logic [7:0] pl;
   logic ov;
   logic z;
   logic dc;
   logic c;
   mmn_phase_t phase;
   logic [31:0] rq;
   logic re;
   logic [31:0] rq0;
   logic re0;
   logic [7:0] wa;
   logic [7:0] wd;
   int wn = 0;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   wire logic [15:0] prod = {ph, pl};
   mmn_exec #(.HAS_MUL(1'b1)) mmn_exec_i (.clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rf_rdata(rf_rdata),
      .rf_addr(rf_addr), .rf_re(rf_re), .rf_we(rf_we), .rf_wdata(rf_wdata),
      .working_accumulator(acc), .product_high_byte(ph), .product_low_byte(pl),
      .overflow_flag(ov), .zero_flag(z), .digit_carry_flag(dc), .carry_flag(c),
      .instr_phase(phase));
   // The reduced variant shares the bus and is judged on what it must lack.
   mmn_exec #(.HAS_MUL(1'b0)) mmn_exec_nomul_i (.clk_sys(clk_sys), .arst_n(arst_n),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(4'hf), .prdata(prdata0), .pready(), .pslverr(pslverr0),
      .rf_rdata(rf_rdata), .rf_addr(), .rf_re(), .rf_we(), .rf_wdata(),
      .working_accumulator(), .product_high_byte(ph0), .product_low_byte(pl0),
      .overflow_flag(), .zero_flag(), .digit_carry_flag(), .carry_flag(), .instr_phase());
   always #50 clk_sys = ~clk_sys;
   // Outside a read the data lines show the inverse so stale values cannot pass.
   always_comb rf_rdata = rf_re ? rf_val : ~rf_val;
   always @(posedge clk_sys)
   begin
      if (rf_we === 1'b1)
      begin
         wa <= rf_addr;
         wd <= rf_wdata;
         wn <= wn + 1;
      end
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         failures++;
         stop_test();
      end
   end
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      rq0 = prdata0;
      re0 = pslverr0;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic run(input logic [15:0] op);
      apb(1'b1, `MMN_OFF_INSTR, {16'h0, op});
      do apb(1'b0, `MMN_OFF_STATUS, 32'h0); while (rq[0] !== 1'b0);
   endtask
   task automatic t_move();
      int n0;
      apb(1'b1, `MMN_OFF_ACC, 32'h4f);
      apb(1'b1, `MMN_OFF_FLAGS, 32'ha);
      n0 = wn;
      run(16'h0112);
      `CHK(wn - n0, 1)
      `CHK({wa, wd, acc}, 24'h124f4f)
      apb(1'b0, `MMN_OFF_FLAGS, 32'h0);
      `CHK(rq, 32'ha)
      $display("test move done");
   endtask
   task automatic t_mul();
      int n0;
      apb(1'b1, `MMN_OFF_ACC, 32'he2);
      apb(1'b1, `MMN_OFF_FLAGS, 32'h0);
      n0 = wn;
      run(16'hbcc4);
      `CHK(prod, 16'had08)
      `CHK(rq0, 32'h6)
      `CHK({ph0, pl0}, 16'h0000)
      apb(1'b0, `MMN_OFF_PROD, 32'h0);
      `CHK(rq, 32'had08)
      `CHK({re0, rq0}, {1'b1, 32'h0})
      run(16'hbc00);
      `CHK({prod, acc}, 24'h0000e2)
      apb(1'b0, `MMN_OFF_FLAGS, 32'h0);
      `CHK(rq, 32'h0)
      apb(1'b1, `MMN_OFF_ACC, 32'hc4);
      apb(1'b1, `MMN_OFF_FLAGS, 32'hf);
      rf_val <= 8'hb5;
      run(16'h3433);
      `CHK({prod, acc}, 24'h8a94c4)
      `CHK(wn - n0, 0)
      apb(1'b0, `MMN_OFF_FLAGS, 32'h0);
      `CHK(rq, 32'hf)
      $display("test multiply done");
   endtask
   task automatic t_neg();
      logic [7:0] av [4] = '{8'h3a, 8'h00, 8'h80, 8'h01};
      logic [7:0] r;
      logic [3:0] f;
      for (int i = 0; i < 4; i++)
      begin
         r = ~av[i] + 8'h01;
         f = {av[i] == 8'h80, r == 8'h00, av[i][3:0] == 4'h0, av[i] == 8'h00};
         apb(1'b1, `MMN_OFF_ACC, {24'h0, av[i]});
         apb(1'b1, `MMN_OFF_FLAGS, 32'h0);
         run({7'h16, i[0], 8'h40 + 8'(i)});
         `CHK({wa, wd}, {8'h40 + 8'(i), r})
         `CHK(acc, i[0] ? av[i] : r)
         `CHK({ov, z, dc, c}, f)
      end
      $display("test negate done");
   endtask
   task automatic t_err();
      apb(1'b0, 12'h020, 32'h0);
      `CHK({re, rq}, {1'b1, 32'h0})
      apb(1'b1, `MMN_OFF_PROD, 32'h1);
      `CHK(re, 1'b1)
      apb(1'b1, `MMN_OFF_RETIRE, 32'h0);
      apb(1'b1, `MMN_OFF_INSTR, 32'h0);
      // A write while the instruction is still in flight must be refused.
      apb(1'b1, `MMN_OFF_ACC, 32'h99);
      `CHK(re, 1'b1)
      do apb(1'b0, `MMN_OFF_STATUS, 32'h0); while (rq[0] !== 1'b0);
      `CHK(acc, 8'h01)
      apb(1'b0, `MMN_OFF_RETIRE, 32'h0);
      `CHK(rq, 32'h1)
      $display("test refusal done");
   endtask
   task automatic stop_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      `CHK({phase, acc, prod}, {MMN_PH_IDLE, 24'h0})
      t_move();
      t_mul();
      t_neg();
      t_err();
      stop_test();
   end
endmodule
`default_nettype wire
